// ===== dv/vis_core_model.sv
// Core exception logic and external controller stand-in.
// Assumes the bench calls one task at a time from one process.
`timescale 1ns/10ps
`default_nettype none
module vis_core_model import vis_pkg::*; #(
	parameter logic [3:0] HS = 4'h3
) (
	input wire logic clk_i,
	output var vis_entry_t entry_o,
	output logic ret_o,
	output var vis_ext_req_t ext_o
);
	initial begin
		entry_o = '0;
		ret_o = 1'b0;
		ext_o = '0;
	end
	// Qualifiers go to junk once valid drops, so nothing leans on old data
	task automatic enter(input logic irq, ds, er, dbg, input logic [2:0] v,
		input logic [4:0] c);
		@(posedge clk_i);
		entry_o <= {1'b1, irq, ds, er, dbg, v, c};
		@(posedge clk_i);
		entry_o <= {1'b0, ~irq, ~ds, ~er, ~dbg, ~v, ~c};
	endtask
	task automatic ret_pulse();
		@(posedge clk_i);
		ret_o <= 1'b1;
		@(posedge clk_i);
		ret_o <= 1'b0;
	endtask
	task automatic ext(input logic [3:0] s, input logic [5:0] p);
		@(posedge clk_i);
		ext_o <= {1'b1, (s > HS) ? HS : s, p};
		@(posedge clk_i);
		ext_o.valid <= 1'b0;
		ext_o.set <= ~s;
	endtask
endmodule
`default_nettype wire

// ===== dv/vis_ctrl_properties.sv
// Port checker for vis_ctrl, bound to every instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module vis_ctrl_props import vis_pkg::*; #(
	parameter logic [3:0] HIGHEST_SET = 4'h3,
	parameter logic [2:0] TIMER_LINE = 3'h7,
	parameter logic [2:0] PERF_LINE = 3'h6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire vis_status_t status_i,
	input wire vis_entry_t entry_i,
	input wire logic exception_return_instr_i,
	input wire logic [3:0] current_set_o,
	input wire logic [3:0] previous_set_o,
	input wire logic [9:0] dispatch_offset_o,
	input wire logic [9:0] vector_spacing_bytes_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req, wr, ev, rt, rb, frz;
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i;
	assign ev = entry_i.valid;
	assign rt = exception_return_instr_i;
	assign rb = status_i.error_level_bit | status_i.boot_vector_bit;
	assign frz = entry_i.sets_error_level | entry_i.debug_entry |
		status_i.exception_level_bit | status_i.boot_vector_bit;
	property p_err; req && wb_adr_i[1:0] != 2'b00 |=>
		wb_err_o && !wb_ack_o && wb_dat_o == 32'h0; endproperty
	a_err: assert property (p_err) else $error("hole not refused");
	property p_ctl; req && !wb_we_i && wb_adr_i == ADDR_INT_CTL |=>
		wb_dat_o[31:26] == {TIMER_LINE, PERF_LINE} &&
		wb_dat_o[25:10] == 16'h0; endproperty
	a_ctl: assert property (p_ctl) else $error("bad control read");
	// Entry on the taking edge would move the set under the captured data
	property p_hss; req && !wb_we_i && !ev && !rt && wb_adr_i == ADDR_SET_CTL
		|=> wb_dat_o[29:26] == HIGHEST_SET &&
		wb_dat_o[3:0] == current_set_o; endproperty
	a_hss: assert property (p_hss) else $error("bad set read");
	property p_save; ev && !frz |=> previous_set_o == $past(current_set_o);
	endproperty
	a_save: assert property (p_save) else $error("set not saved");
	property p_frz; ev && frz && !rt && !wr |=>
		$stable(current_set_o) && $stable(previous_set_o); endproperty
	a_frz: assert property (p_frz) else $error("frozen set moved");
	property p_ret; rt && !ev && !rb && !wr |=>
		current_set_o == $past(previous_set_o); endproperty
	a_ret: assert property (p_ret) else $error("set not restored");
	property p_nret; rt && rb && !ev |=> $stable(current_set_o); endproperty
	a_nret: assert property (p_nret) else $error("set restored");
	property p_hold; !ev && !rt |=> $stable(current_set_o); endproperty
	a_hold: assert property (p_hold) else $error("set changed");
	property p_disp; req && wb_we_i && wb_adr_i == ADDR_CAUSE && wb_sel_i[2]
		|-> ##2 dispatch_offset_o == ($past(wb_dat_i[23], 2) ?
		INT_VEC_OFF : GEN_VEC_OFF); endproperty
	a_disp: assert property (p_disp) else $error("bad dispatch");
	property p_vs; vector_spacing_bytes_o inside
		{10'h000, 10'h020, 10'h040, 10'h080, 10'h100, 10'h200}; endproperty
	a_vs: assert property (p_vs) else $error("bad spacing");
	c_ent: cover property (ev && !frz);
	c_ret: cover property (rt && !rb);
	c_err: cover property (wb_err_o);
endmodule
bind vis_ctrl vis_ctrl_props #(.HIGHEST_SET(HIGHEST_SET),
	.TIMER_LINE(TIMER_LINE), .PERF_LINE(PERF_LINE)) u_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.wb_err_o(wb_err_o), .status_i(status_i), .entry_i(entry_i),
	.exception_return_instr_i(exception_return_instr_i),
	.current_set_o(current_set_o), .previous_set_o(previous_set_o),
	.dispatch_offset_o(dispatch_offset_o),
	.vector_spacing_bytes_o(vector_spacing_bytes_o));
`default_nettype wire

// ===== dv/vis_ctrl_tb_top.sv
// Bench for vis_ctrl: bus reads scored from a queue, ports checked.
// Assumes the core model supplies entry, return and controller events.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module vis_ctrl_tb_top import vis_pkg::*; ;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, cs, ps, sel = 4'hF;
	logic [31:0] wdat = 32'h0, rdat, m, e, m0, r, q;
	logic wd = 1'b0;
	logic ack, err, xm = 1'b0, vp = 1'b0, ti = 1'b0, pi = 1'b0, cdis, ret;
	logic [5:0] hw = 6'h00;
	logic [1:0] swr;
	logic [9:0] dof, vsb;
	vis_status_t st = '0;
	vis_entry_t ent;
	vis_ext_req_t xr;
	logic [31:0] exp_q[$], msk_q[$];
	logic [4:0] vsc[6] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
	logic [9:0] vsx[6] = '{10'h000, 10'h020, 10'h040, 10'h080, 10'h100,
		10'h200};
	int n_mismatch = 0, n_tests = 0, v;
	vis_core_model #(.HS(4'h3)) core (.clk_i(clk_i), .entry_o(ent),
		.ret_o(ret), .ext_o(xr));
	vis_ctrl #(.HIGHEST_SET(4'h3), .TIMER_LINE(3'h7), .PERF_LINE(3'h6)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.external_ctrl_mode_enable_i(xm), .vectored_mode_present_i(vp),
		.status_i(st), .entry_i(ent), .exception_return_instr_i(ret),
		.ext_req_i(xr), .hw_irq_i(hw), .timer_irq_i(ti), .perf_irq_i(pi),
		.watch_deferred_i(wd), .current_set_o(cs), .previous_set_o(ps),
		.software_request_bits_o(swr), .count_disable_o(cdis),
		.dispatch_offset_o(dof), .vector_spacing_bytes_o(vsb));
	initial forever #25 clk_i = ~clk_i;
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, x, k);
		if (!w) begin
			exp_q.push_back(x);
			msk_q.push_back(k);
		end
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
		end while (!(ack || err));
		{cyc, stb, we} <= 3'b000;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] x, k);
		wb(1'b0, a, 32'h0, x, k);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 32'h0, 32'h0);
	endtask
	task automatic sst(input vis_status_t s);
		@(posedge clk_i);
		st <= s;
	endtask
	// Sampled before the edge's updates land, so ack and data line up
	always @(posedge clk_i) begin
		if (cyc && !we && (ack || err)) begin
			q = exp_q.pop_front();
			m = msk_q.pop_front();
			`CHK(rdat & m, q & m)
		end
	end
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		void'($urandom(32'h87F1E5E7));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(ADDR_INT_CTL, 32'hF800_0000, '1);
		rd(ADDR_SET_CTL, 32'h0C00_0000, '1);
		rd(ADDR_SET_MAP, MAP_RST, '1);
		rd(ADDR_CAUSE, 32'h0, '1);
		rd(4'h2, 32'h0, '1);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_INT_CTL, 32'hFC00_0000 | {vsc[i], 5'h00});
			rd(ADDR_INT_CTL, 32'hF800_0000 | {vsc[i], 5'h00}, '1);
			`CHK(vsb, vsx[i])
		end
		$display("spacing test done");
		m0 = $urandom & 32'h3333_3333;
		m0[7:4] = m0[3:0];
		wr(ADDR_SET_MAP, m0);
		rd(ADDR_SET_MAP, m0, '1);
		wr(ADDR_SET_CTL, 32'h0000_2043);
		rd(ADDR_SET_CTL, 32'h0C00_2040, '1);
		core.ret_pulse();
		#1 `CHK(cs, 4'h1)
		core.enter(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 5'h04);
		#1 `CHK({ps, cs}, 8'h12)
		for (int i = 0; i < 4; i++) begin
			sst(i == 0 ? 3'b100 : (i == 1 ? 3'b001 : 3'b000));
			core.enter(1'b0, 1'b0, i == 2, i == 3, 3'h0, 5'h0D);
			#1 `CHK({ps, cs}, 8'h12)
		end
		for (int i = 0; i < 2; i++) begin
			sst(i == 0 ? 3'b010 : 3'b001);
			core.ret_pulse();
			#1 `CHK(cs, 4'h2)
		end
		sst(3'b000);
		core.ret_pulse();
		#1 `CHK(cs, 4'h1)
		$display("set switch test done");
		@(posedge clk_i) vp <= 1'b1;
		wr(ADDR_CAUSE, 32'h0880_0300);
		#1 `CHK({swr, cdis, dof}, {3'b111, INT_VEC_OFF})
		v = $urandom_range(7);
		core.enter(1'b1, 1'b0, 1'b0, 1'b0, v[2:0], 5'h00);
		#1 `CHK({ps, cs}, {4'h1, m0[v * 4 +: 4]})
		wr(ADDR_INT_CTL, 32'h0);
		core.enter(1'b1, 1'b0, 1'b0, 1'b0, v[2:0], 5'h00);
		#1 `CHK(cs, 4'h2)
		r = $urandom;
		@(posedge clk_i) xm <= 1'b1;
		core.ext(4'h3, r[13:8]);
		core.enter(1'b1, 1'b0, 1'b0, 1'b0, v[2:0], 5'h00);
		#1 `CHK(cs, 4'h3)
		rd(ADDR_SET_CTL, 32'h0C0C_2083, '1);
		$display("vector test done");
		@(posedge clk_i) {hw, pi, ti} <= {r[5:0], r[6], 1'b1};
		core.enter(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 5'h0D);
		sst(3'b100);
		core.enter(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 5'h08);
		e = 32'hC880_0320 | {5'h0, r[6], 26'h0};
		rd(ADDR_CAUSE, e | {16'h0, r[13:8], 10'h0}, '1);
		@(posedge clk_i) xm <= 1'b0;
		e = e | {16'h0, r[5:0] | 6'h20 | {1'b0, r[6], 4'h0}, 10'h0};
		rd(ADDR_CAUSE, e, '1);
		@(posedge clk_i) wd <= 1'b1;
		wr(ADDR_CAUSE, 32'h0880_0300);
		rd(ADDR_CAUSE, e | 32'h0040_0000, '1);
		@(posedge clk_i) wd <= 1'b0;
		wr(ADDR_CAUSE, 32'h0880_0300);
		rd(ADDR_CAUSE, e, '1);
		@(posedge clk_i) sel <= 4'h2;
		wr(ADDR_SET_MAP, 32'h0000_0000);
		@(posedge clk_i) sel <= 4'hF;
		rd(ADDR_SET_MAP, m0 & 32'hFFFF_00FF, '1);
		$display("cause test done");
		end_of_test();
	end
endmodule
`default_nettype wire

// ===== rtl/vis_ctrl.sv
// Vectored interrupt control, shadow-set control, vector-to-set map
// and the lower cause fields, as Wishbone classic slave registers.
// Assumes the core presents entry and return events as one-cycle
// pulses and an external controller gives set and level per request.
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

module vis_ctrl import vis_pkg::*; #(
	parameter logic [3:0] HIGHEST_SET = 4'h3,
	parameter logic [2:0] TIMER_LINE = 3'h7,
	parameter logic [2:0] PERF_LINE = 3'h6
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic external_ctrl_mode_enable_i,
	input wire logic vectored_mode_present_i,
	input wire vis_status_t status_i,
	input wire vis_entry_t entry_i,
	input wire logic exception_return_instr_i,
	input wire vis_ext_req_t ext_req_i,
	input wire logic [5:0] hw_irq_i,
	input wire logic timer_irq_i,
	input wire logic perf_irq_i,
	input wire logic watch_deferred_i,
	output logic [3:0] current_set_o,
	output logic [3:0] previous_set_o,
	output logic [1:0] software_request_bits_o,
	output logic count_disable_o,
	output logic [9:0] dispatch_offset_o,
	output logic [9:0] vector_spacing_bytes_o
);

	// Lines 0 and 1 are the software requests; no source merges there
	if (TIMER_LINE < 3'h2 || PERF_LINE < 3'h2) begin : g_bad_line
		$error("Interrupt line numbers must be 2 to 7");
	end

	logic [4:0] vector_spacing;
	logic [3:0] external_ctrl_set;
	logic [3:0] exception_set;
	logic [3:0] previous_set;
	logic [3:0] current_set;
	logic [31:0] vector_to_set_map;
	logic delay_slot_flag;
	logic special_vector_select;
	logic count_disable;
	logic watch_flag;
	logic [1:0] software_request_bits;
	logic [5:0] hardware_pending_bits;
	logic [4:0] exc_code;
	logic timer_pending_flag;
	logic perf_pending_flag;
	logic ack;
	logic [31:0] next_rdata;
	logic [3:0] next_set;
	vis_src_t set_src;
	logic wr_req;
	logic entry_switches;
	logic ret_restores;

	// Byte lanes outside sel keep their stored value
	function automatic logic [31:0] merge_bytes(input logic [31:0] old,
			input logic [31:0] wdat, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				res[i*8 +: 8] = wdat[i*8 +: 8];
		return res;
	endfunction

	// Reserved codes give no spacing rather than an undefined one
	function automatic logic [9:0] spacing_bytes(input logic [4:0] code);
		logic [9:0] res;
		res = 10'h000;
		unique case (code)
			VS_32: res = 10'h020;
			VS_64: res = 10'h040;
			VS_128: res = 10'h080;
			VS_256: res = 10'h100;
			VS_512: res = 10'h200;
			default: res = 10'h000;
		endcase
		return res;
	endfunction

	// Write strobe of one register, taken with the request edge
	function automatic logic reg_write(input logic req,
			input logic [3:0] adr, input logic [3:0] target);
		return req && adr == target;
	endfunction

	// Classic Wishbone: one wait state, ack drops after one cycle
	// A write lands on the taking edge, the same edge that raises its ack
	assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !ack;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack <= 1'b0;
		else
			ack <= wb_cyc_i && wb_stb_i && !ack;
	end

	logic [31:0] wr_int_ctl, wr_set_ctl, wr_map, wr_cause;
	logic [31:0] rd_int_ctl, rd_set_ctl, rd_cause;
	logic addr_ok;

	// Holes are answered with err so a stray access stays visible
	assign addr_ok = wb_adr_i == ADDR_INT_CTL || wb_adr_i == ADDR_SET_CTL
		|| wb_adr_i == ADDR_SET_MAP || wb_adr_i == ADDR_CAUSE;
	assign wr_int_ctl = merge_bytes(rd_int_ctl, wb_dat_i, wb_sel_i);
	assign wr_set_ctl = merge_bytes(rd_set_ctl, wb_dat_i, wb_sel_i);
	assign wr_map = merge_bytes(vector_to_set_map, wb_dat_i, wb_sel_i);
	assign wr_cause = merge_bytes(rd_cause, wb_dat_i, wb_sel_i);

	// Reserved ranges are simply never stored, so they read zero
	always_comb begin
		rd_int_ctl = 32'h0000_0000;
		rd_int_ctl[TIMER_LINE_LSB +: 3] = TIMER_LINE;
		rd_int_ctl[PERF_LINE_LSB +: 3] = PERF_LINE;
		rd_int_ctl[VSPACE_LSB +: 5] = vector_spacing;
	end

	// External set flop is held clear outside external mode, so reads zero
	always_comb begin
		rd_set_ctl = 32'h0000_0000;
		rd_set_ctl[HIGHEST_LSB +: 4] = HIGHEST_SET;
		rd_set_ctl[EXTSET_LSB +: 4] = external_ctrl_set;
		rd_set_ctl[EXCSET_LSB +: 4] = exception_set;
		rd_set_ctl[PREVSET_LSB +: 4] = previous_set;
		rd_set_ctl[CURSET_LSB +: 4] = current_set;
	end

	always_comb begin
		rd_cause = 32'h0000_0000;
		rd_cause[DSLOT_BIT] = delay_slot_flag;
		rd_cause[TIMER_PEND_BIT] = timer_pending_flag;
		rd_cause[CDIS_BIT] = count_disable;
		rd_cause[PERF_PEND_BIT] = perf_pending_flag;
		rd_cause[SPECV_BIT] = special_vector_select;
		rd_cause[WATCH_BIT] = watch_flag;
		rd_cause[HWPEND_LSB +: 6] = hardware_pending_bits;
		rd_cause[SWREQ_LSB +: 2] = software_request_bits;
		rd_cause[EXCCODE_LSB +: 5] = exc_code;
	end

	// Read data is latched on the taking edge and held to the next request
	always_comb begin
		unique case (wb_adr_i)
			ADDR_INT_CTL: next_rdata = rd_int_ctl;
			ADDR_SET_CTL: next_rdata = rd_set_ctl;
			ADDR_SET_MAP: next_rdata = vector_to_set_map;
			ADDR_CAUSE: next_rdata = rd_cause;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_cyc_i && wb_stb_i && !ack)
			wb_dat_o <= next_rdata;
	end

	assign wb_ack_o = ack && addr_ok;
	assign wb_err_o = ack && !addr_ok;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			vector_spacing <= VSPACE_RST;
		else if (reg_write(wr_req, wb_adr_i, ADDR_INT_CTL))
			vector_spacing <= wr_int_ctl[VSPACE_LSB +: 5];
	end

	// New set source selection
	// Map only when vector bit, vectored mode and a nonzero spacing agree
	always_comb begin
		if (!entry_i.is_irq || !special_vector_select)
			set_src = SRC_EXC;
		else if (external_ctrl_mode_enable_i)
			set_src = SRC_EXT;
		else if (vectored_mode_present_i && vector_spacing != VS_0)
			set_src = SRC_MAP;
		else
			set_src = SRC_EXC;
		unique case (set_src)
			SRC_MAP: next_set = vector_to_set_map[
				{entry_i.vector_number, 2'b00} +: 4];
			SRC_EXT: next_set = external_ctrl_set;
			default: next_set = exception_set;
		endcase
	end

	// Frozen entries keep both fields, so a nested handler keeps the pair
	assign entry_switches = entry_i.valid && !entry_i.sets_error_level
		&& !entry_i.debug_entry && !status_i.exception_level_bit
		&& !status_i.boot_vector_bit;
	assign ret_restores = exception_return_instr_i
		&& !status_i.error_level_bit && !status_i.boot_vector_bit;

	// External set follows each request in external mode only
	always_ff @(posedge clk_i) begin
		if (rst_i || !external_ctrl_mode_enable_i)
			external_ctrl_set <= SET_RST;
		else if (ext_req_i.valid)
			external_ctrl_set <= ext_req_i.set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			exception_set <= SET_RST;
		else if (reg_write(wr_req, wb_adr_i, ADDR_SET_CTL))
			exception_set <= wr_set_ctl[EXCSET_LSB +: 4];
	end

	// Hardware entry wins over a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			previous_set <= SET_RST;
		else if (entry_switches)
			previous_set <= current_set;
		else if (reg_write(wr_req, wb_adr_i, ADDR_SET_CTL))
			previous_set <= wr_set_ctl[PREVSET_LSB +: 4];
	end

	// Current set moves only by entry or return, never by a bus write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			current_set <= SET_RST;
		else if (entry_switches)
			current_set <= next_set;
		else if (ret_restores)
			current_set <= previous_set;
	end

	// Entries above the highest set are not clipped; that is the writer's duty
	always_ff @(posedge clk_i) begin
		if (rst_i)
			vector_to_set_map <= MAP_RST;
		else if (reg_write(wr_req, wb_adr_i, ADDR_SET_MAP))
			vector_to_set_map <= wr_map;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			special_vector_select <= 1'b0;
		else if (reg_write(wr_req, wb_adr_i, ADDR_CAUSE))
			special_vector_select <= wr_cause[SPECV_BIT];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			count_disable <= 1'b0;
		else if (reg_write(wr_req, wb_adr_i, ADDR_CAUSE))
			count_disable <= wr_cause[CDIS_BIT];
	end

	// Request bits feed the core's own software interrupt logic
	always_ff @(posedge clk_i) begin
		if (rst_i)
			software_request_bits <= 2'b00;
		else if (reg_write(wr_req, wb_adr_i, ADDR_CAUSE))
			software_request_bits <= wr_cause[SWREQ_LSB +: 2];
	end

	// Watch deferral: hardware set wins over a software clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			watch_flag <= 1'b0;
		else if (watch_deferred_i)
			watch_flag <= 1'b1;
		else if (reg_write(wr_req, wb_adr_i, ADDR_CAUSE))
			watch_flag <= wr_cause[WATCH_BIT];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			delay_slot_flag <= 1'b0;
		else if (entry_i.valid && !entry_i.debug_entry
				&& !status_i.exception_level_bit)
			delay_slot_flag <= entry_i.in_delay_slot;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			exc_code <= 5'h00;
		else if (entry_i.valid && !entry_i.debug_entry)
			exc_code <= entry_i.exc_code;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			timer_pending_flag <= 1'b0;
		else
			timer_pending_flag <= timer_irq_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			perf_pending_flag <= 1'b0;
		else
			perf_pending_flag <= perf_irq_i;
	end

	// Pending bits: priority level in external mode, else merged lines
	always_ff @(posedge clk_i) begin
		if (rst_i)
			hardware_pending_bits <= 6'h00;
		else if (external_ctrl_mode_enable_i)
			hardware_pending_bits <= ext_req_i.priority_level;
		else
			hardware_pending_bits <= hw_irq_i
				| (timer_irq_i ? 6'(1) << (TIMER_LINE - 3'h2) : 6'h00)
				| (perf_irq_i ? 6'(1) << (PERF_LINE - 3'h2) : 6'h00);
	end

	assign current_set_o = current_set;
	assign previous_set_o = previous_set;
	assign software_request_bits_o = software_request_bits;
	assign count_disable_o = count_disable;

	// Dispatch offset lags a write of the vector bit by one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dispatch_offset_o <= GEN_VEC_OFF;
		else
			dispatch_offset_o <= special_vector_select
				? INT_VEC_OFF : GEN_VEC_OFF;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			vector_spacing_bytes_o <= 10'h000;
		else
			vector_spacing_bytes_o <= spacing_bytes(vector_spacing);
	end

endmodule
`default_nettype wire

// ===== rtl/vis_pkg.sv
// Package for the vectored interrupt and shadow-set control block.
// Assumes a 32-bit classic Wishbone register bus and one core clock.
package vis_pkg;

	// Register byte offsets
	localparam logic [3:0] ADDR_INT_CTL = 4'h0;
	localparam logic [3:0] ADDR_SET_CTL = 4'h4;
	localparam logic [3:0] ADDR_SET_MAP = 4'h8;
	localparam logic [3:0] ADDR_CAUSE = 4'hC;

	// Interrupt control field positions
	localparam int TIMER_LINE_LSB = 29;
	localparam int PERF_LINE_LSB = 26;
	localparam int VSPACE_LSB = 5;

	// Shadow-set control field positions
	localparam int HIGHEST_LSB = 26;
	localparam int EXTSET_LSB = 18;
	localparam int EXCSET_LSB = 12;
	localparam int PREVSET_LSB = 6;
	localparam int CURSET_LSB = 0;

	// Cause field positions
	localparam int DSLOT_BIT = 31;
	localparam int TIMER_PEND_BIT = 30;
	localparam int CDIS_BIT = 27;
	localparam int PERF_PEND_BIT = 26;
	localparam int SPECV_BIT = 23;
	localparam int WATCH_BIT = 22;
	localparam int HWPEND_LSB = 10;
	localparam int SWREQ_LSB = 8;
	localparam int EXCCODE_LSB = 2;

	// Reset values
	localparam logic [4:0] VSPACE_RST = 5'h00;
	localparam logic [3:0] SET_RST = 4'h0;
	localparam logic [31:0] MAP_RST = 32'h0000_0000;

	// Legal vector spacing codes and their byte spacings
	localparam logic [4:0] VS_0 = 5'h00;
	localparam logic [4:0] VS_32 = 5'h01;
	localparam logic [4:0] VS_64 = 5'h02;
	localparam logic [4:0] VS_128 = 5'h04;
	localparam logic [4:0] VS_256 = 5'h08;
	localparam logic [4:0] VS_512 = 5'h10;

	// Dispatch offsets of the two interrupt vectors
	localparam logic [9:0] GEN_VEC_OFF = 10'h180;
	localparam logic [9:0] INT_VEC_OFF = 10'h200;

	// Exception entry event from the core
	typedef struct packed {
		logic valid;
		logic is_irq;
		logic in_delay_slot;
		logic sets_error_level;
		logic debug_entry;
		logic [2:0] vector_number;
		logic [4:0] exc_code;
	} vis_entry_t;

	// Core status bits that steer set switching
	typedef struct packed {
		logic exception_level_bit;
		logic error_level_bit;
		logic boot_vector_bit;
	} vis_status_t;

	// External controller request
	typedef struct packed {
		logic valid;
		logic [3:0] set;
		logic [5:0] priority_level;
	} vis_ext_req_t;

	typedef enum logic [1:0] {
		SRC_EXC = 2'b00,
		SRC_MAP = 2'b01,
		SRC_EXT = 2'b10
	} vis_src_t;

endpackage
